//--- rtl/lcg_top.sv
// Chosen here: the AXI4-Lite slave port.
`include "lcg_defines.svh"
module lcg_top
   import lcg_pkg::*;
#(
   parameter int FRAMER_NUM   = 1,
   parameter int INTEG_CYCLES = `LCG_INTEG_CYC,
   parameter int ADDR_W       = 14
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // register bus write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // register bus read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // transmit stream
   input  wire lcg_line_t         tx_line_in,
   output logic                   tx_data_out,
   output logic                   tx_bit_valid,
   output logic                   tx_loop_active,
   // receive stream
   input  wire lcg_line_t         rx_line_in,
   // interrupt
   output logic                   loop_code_irq
);
   if (FRAMER_NUM < 1 || FRAMER_NUM > 4)
      $error("framer number out of range");
   if (ADDR_W < 14)
      $error("address too narrow");

   localparam logic [10:0] BASE =
      11'(`LCG_STRIDE * (FRAMER_NUM - 1));
   localparam logic [10:0] OFFS [16] = '{
      `LCG_IX_RX_LEN, `LCG_IX_LATCH, `LCG_IX_SP_HI, `LCG_IX_SP_LO,
      `LCG_IX_MASK, `LCG_IX_UP_HI, `LCG_IX_UP_LO, `LCG_IX_DN_HI,
      `LCG_IX_DN_LO, `LCG_IX_LIVE, `LCG_IX_TX_CTL3, `LCG_IX_TX_CTL4,
      `LCG_IX_TX_CODE1, `LCG_IX_TX_CODE2, `LCG_IX_SP_LEN, `LCG_IX_MODE
   };
   // latched and live slots are not plain storage
   localparam logic [15:0] RW_MASK = 16'hfdfd;
   localparam int R_LEN  = 0;
   localparam int R_LAT  = 1;
   localparam int R_SPH  = 2;
   localparam int R_SPL  = 3;
   localparam int R_MASK = 4;
   localparam int R_UPH  = 5;
   localparam int R_UPL  = 6;
   localparam int R_DNH  = 7;
   localparam int R_DNL  = 8;
   localparam int R_LIVE = 9;
   localparam int R_TXC3 = 10;
   localparam int R_TXC4 = 11;
   localparam int R_TXD1 = 12;
   localparam int R_TXD2 = 13;
   localparam int R_SPLN = 14;
   localparam int R_MODE = 15;

   // one-hot register select; misaligned or foreign words hit nothing
   function automatic logic [15:0] dec(input logic [ADDR_W-1:0] a);
      logic [10:0] ix;
      ix = a[12:2] - BASE;
      for (int i = 0; i < 16; i++)
         dec[i] = (ix == OFFS[i]);
      if (a[1:0] != 2'b00 || a[ADDR_W-1:13] != '0)
         dec = 16'h0000;
   endfunction : dec

   logic [7:0]        rw_q [16];
   logic [7:0]        lat;
   logic [2:0]        live;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0]        w_byte;
   logic              w_lane0;
   lcg_bus_st_t       wr_st;
   lcg_bus_st_t       next_wr_st;
   logic [31:0]       next_rdata;
   logic [7:0]        fcnt;
   logic [3:0]        ptr;

   wire [15:0]    aw_sel  = dec(aw_addr);
   wire [15:0]    rd_sel  = dec(s_axi_araddr);
   wire           wr_go   = (wr_st == LCG_BUS_IDLE) && !s_axi_awready && !s_axi_wready;
   wire [15:0]    wr_sel  = aw_sel & {16{wr_go && w_lane0}};
   wire           aw_fire = s_axi_awvalid && s_axi_awready;
   wire           w_fire  = s_axi_wvalid && s_axi_wready;
   wire           b_fire  = s_axi_bvalid && s_axi_bready;
   wire           ar_fire = s_axi_arvalid && s_axi_arready;
   wire           r_fire  = s_axi_rvalid && s_axi_rready;

   // mode and transmit control
   wire           t1      = rw_q[R_MODE][`LCG_MODE_T1];
   wire           nofbit  = rw_q[R_MODE][`LCG_MODE_NOFBIT];
   wire           loop_en = rw_q[R_TXC3][`LCG_LOOP_EN_BIT];
   wire           active  = t1 && loop_en;
   wire [4:0]     tx_len  = lcg_len_of(rw_q[R_TXC4][3:0]);
   wire [4:0]     tx_lm1  = tx_len - 5'd1;
   wire           pow2    = (tx_len & tx_lm1) == 5'd0;
   wire [15:0]    two     = {rw_q[R_TXD1], rw_q[R_TXD2]};
   wire [3:0]     wrap    = pow2 ? 4'hf : tx_lm1[3:0];
   wire [2:0]     sh_ix   = 3'd7 - ptr[2:0];
   wire [3:0]     lg_ix   = 4'hf - ptr;
   wire           pat_bit = pow2 ? two[lg_ix] : rw_q[R_TXD1][sh_ix];
   wire           fpos    = tx_line_in.fsync || (fcnt == 8'd0);
   wire           keep_f  = fpos && !nofbit;
   wire           next_tx = (active && !keep_f) ? pat_bit : tx_line_in.data;

   // detector wiring
   lcg_code_cfg_t cfg [3];
   wire [2:0]     restart = {wr_sel[R_SPL], wr_sel[R_DNL], wr_sel[R_UPL]};
   wire [2:0]     det;
   wire [2:0]     rise    = det & ~live;
   wire [2:0]     fall    = ~det & live;
   wire [7:0]     lat_clr = wr_sel[R_LAT] ? w_byte : 8'h00;
   wire [7:0]     lat_set = {1'b0, fall, 1'b0, rise};
   wire [7:0]     next_lat = (lat & ~lat_clr) | lat_set;

   assign cfg[0] = '{hi: rw_q[R_UPH], lo: rw_q[R_UPL], len: rw_q[R_LEN][3:0]};
   assign cfg[1] = '{hi: rw_q[R_DNH], lo: rw_q[R_DNL], len: rw_q[R_LEN][7:4]};
   assign cfg[2] = '{hi: rw_q[R_SPH], lo: rw_q[R_SPL], len: rw_q[R_SPLN][3:0]};

   for (genvar g = 0; g < 3; g++)
   begin : g_det
      lcg_detector #(
         .INTEG_CYCLES (INTEG_CYCLES)
      ) u_det (
         .clk      (clk),
         .sys_rst  (sys_rst),
         .enable   (t1),
         .restart  (restart[g]),
         .cfg      (cfg[g]),
         .bit_en   (rx_line_in.en),
         .bit_in   (rx_line_in.data),
         .detected (det[g])
      );
   end

   // write address and data are taken in either order
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         s_axi_awready <= 1'b1;
      else if (aw_fire)
         s_axi_awready <= 1'b0;
      else if (b_fire)
         s_axi_awready <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         s_axi_wready <= 1'b1;
      else if (w_fire)
         s_axi_wready <= 1'b0;
      else if (b_fire)
         s_axi_wready <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         aw_addr <= '0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end
      else
      begin
         if (aw_fire)
            aw_addr <= s_axi_awaddr;
         if (w_fire)
         begin
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
      end
   end

   always_comb
   begin
      case (wr_st)
         LCG_BUS_IDLE: next_wr_st = wr_go ? LCG_BUS_RESP : LCG_BUS_IDLE;
         LCG_BUS_RESP: next_wr_st = b_fire ? LCG_BUS_IDLE : LCG_BUS_RESP;
         default:      next_wr_st = LCG_BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_st        <= LCG_BUS_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `LCG_RESP_OKAY;
      end
      else
      begin
         wr_st        <= next_wr_st;
         s_axi_bvalid <= (next_wr_st == LCG_BUS_RESP);
         if (wr_go)
            s_axi_bresp <= (aw_sel != 16'h0000) ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
      end
   end

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 16; i++)
      begin
         if (sys_rst)
            rw_q[i] <= (i == R_MODE) ? `LCG_RST_MODE : `LCG_RST_BYTE;
         else if (wr_sel[i] && RW_MASK[i])
            rw_q[i] <= w_byte;
      end
   end

   // read answers one cycle after the address is taken
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      for (int i = 0; i < 16; i++)
      begin
         if (rd_sel[i])
         begin
            if (i == R_LAT)
               next_rdata[7:0] = next_rdata[7:0] | lat;
            else if (i == R_LIVE)
               next_rdata[7:0] = next_rdata[7:0] | {5'b0_0000, live};
            else
               next_rdata[7:0] = next_rdata[7:0] | rw_q[i];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `LCG_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= (rd_sel != 16'h0000) ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
      end
      else if (r_fire)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // status; a set in the clearing cycle survives the clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         live          <= 3'b000;
         lat           <= 8'h00;
         loop_code_irq <= 1'b0;
      end
      else
      begin
         live          <= det;
         lat           <= next_lat;
         loop_code_irq <= |(lat & rw_q[R_MASK]);
      end
   end

   // frame position and pattern pointer follow the line bit strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         fcnt <= 8'd0;
      else if (tx_line_in.en)
      begin
         if (tx_line_in.fsync)
            fcnt <= 8'd1;
         else if (fcnt == `LCG_FRAME_LAST)
            fcnt <= 8'd0;
         else
            fcnt <= fcnt + 8'd1;
      end
   end

   // framing bit slots still advance the pointer: they overwrite code bits
   always_ff @(posedge clk)
   begin
      if (sys_rst || !active)
         ptr <= 4'h0;
      else if (tx_line_in.en)
         ptr <= (ptr >= wrap) ? 4'h0 : ptr + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         tx_data_out    <= 1'b0;
         tx_bit_valid   <= 1'b0;
         tx_loop_active <= 1'b0;
      end
      else
      begin
         tx_bit_valid   <= tx_line_in.en;
         tx_loop_active <= active;
         if (tx_line_in.en)
            tx_data_out <= next_tx;
      end
   end

   property p_fbit;
      @(posedge clk) disable iff (sys_rst)
      tx_line_in.en && fpos && !nofbit |=> tx_data_out == $past(tx_line_in.data);
   endproperty
   a_fbit: assert property (p_fbit) else $error("framing bit lost");

   property p_pattern;
      @(posedge clk) disable iff (sys_rst)
      tx_line_in.en && active && !keep_f |=> tx_data_out == $past(pat_bit);
   endproperty
   a_pattern: assert property (p_pattern) else $error("pattern bit wrong");

   property p_e1;
      @(posedge clk) disable iff (sys_rst)
      !t1 |=> !tx_loop_active;
   endproperty
   a_e1: assert property (p_e1) else $error("generator on outside T1");

   property p_set;
      @(posedge clk) disable iff (sys_rst)
      $rose(live[0]) |-> lat[0];
   endproperty
   a_set: assert property (p_set) else $error("up set not latched");

   property p_irq;
      @(posedge clk) disable iff (sys_rst)
      (lat[2] && rw_q[R_MASK][2]) [*2] |-> loop_code_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("masked-in event lost");
endmodule : lcg_top

//--- rtl/lcg_defines.svh
`ifndef LCG_DEFINES_SVH
`define LCG_DEFINES_SVH
// Contract
// - codes of one to eight bits or sixteen bits are sent and found
// - generator and detectors work only in T1 mode
// - lengths 3, 5, 6, 7 send only the first transmit byte
// - pattern repeats while the transmit loop enable is set
// - framing bit overwrites the pattern once per 193 bits
// - three detectors: loop-up, loop-down and spare
// - up and down lengths come from the receive length register
// - spare uses its own code bytes and its own length register
// - sixteen-bit length joins both code bytes into one reference
// - one to eight bits compare only the first code byte
// - framed or unframed data, up to one error per hundred bits
// - framing bits inserted or overwriting the code are tolerated
// - writing a low code byte restarts that integration period
// - code present for about 48 ms sets the detect bit
// - live bit plus latched set and latched clear bits per detector
// - one mask bit per latched detect bit
// - framer n sits at framer one offset plus (n-1) times 0x200
`define LCG_IX_RX_LEN   11'h082
`define LCG_IX_LATCH    11'h092
`define LCG_IX_SP_HI    11'h09c
`define LCG_IX_SP_LO    11'h09d
`define LCG_IX_MASK     11'h0a2
`define LCG_IX_UP_HI    11'h0ac
`define LCG_IX_UP_LO    11'h0ad
`define LCG_IX_DN_HI    11'h0ae
`define LCG_IX_DN_LO    11'h0af
`define LCG_IX_LIVE     11'h0b2
`define LCG_IX_TX_CTL3  11'h183
`define LCG_IX_TX_CTL4  11'h186
`define LCG_IX_TX_CODE1 11'h1ac
`define LCG_IX_TX_CODE2 11'h1ad
`define LCG_IX_SP_LEN   11'h0be
`define LCG_IX_MODE     11'h0bf
`define LCG_STRIDE      512
`define LCG_LOOP_EN_BIT 0
`define LCG_MODE_T1     0
`define LCG_MODE_NOFBIT 1
`define LCG_CLR_SHIFT   4
`define LCG_RST_BYTE    8'h00
`define LCG_RST_MODE    8'h01
`define LCG_FRAME_LAST  8'd192
`define LCG_INTEG_MS    48
`define LCG_CLK_KHZ     125000
`define LCG_INTEG_CYC   (`LCG_INTEG_MS * `LCG_CLK_KHZ)
`define LCG_RESP_OKAY   2'b00
`define LCG_RESP_SLVERR 2'b10
`endif

//--- rtl/lcg_pkg.sv
package lcg_pkg;
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic [3:0] len;
   } lcg_code_cfg_t;
   typedef struct packed {
      logic en;
      logic fsync;
      logic data;
   } lcg_line_t;
   typedef enum logic [1:0] {
      LCG_BUS_IDLE = 2'b01,
      LCG_BUS_RESP = 2'b10
   } lcg_bus_st_t;
   // code 0..7 is 1..8 bits, 8..15 is 16 bits
   function automatic logic [4:0] lcg_len_of(input logic [3:0] code);
      lcg_len_of = code[3] ? 5'd16 : {2'b00, code[2:0]} + 5'd1;
   endfunction : lcg_len_of
endpackage : lcg_pkg

//--- rtl/lcg_detector.sv
`include "lcg_defines.svh"
module lcg_detector
   import lcg_pkg::*;
#(
   parameter int INTEG_CYCLES = `LCG_INTEG_CYC
)
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // control
   input  wire logic          enable,
   input  wire logic          restart,
   input  wire lcg_code_cfg_t cfg,
   // line bits
   input  wire logic          bit_en,
   input  wire logic          bit_in,
   // result
   output logic               detected
);
   localparam int CW = $clog2(INTEG_CYCLES + 1);
   if (INTEG_CYCLES < 2)
      $error("integration window too short");

   logic [15:0]   hist;
   logic [CW-1:0] cyc_cnt;
   logic [CW-1:0] bit_cnt;
   logic [CW-1:0] bad_cnt;
   wire  [4:0]    len = lcg_len_of(cfg.len);
   wire  [15:0]   ref_bits;
   wire           match;
   wire           win_end;
   wire           pass;

   // any rotation of the reference counts, so no bit alignment needed
   function automatic logic rot_match(input logic [15:0] h,
                                      input logic [15:0] r,
                                      input logic [4:0]  l);
      logic ok;
      int   j;
      rot_match = 1'b0;
      for (int ph = 0; ph < 16; ph++)
      begin
         ok = (ph < l);
         for (int i = 0; i < 16; i++)
         begin
            j = (i + ph >= l) ? i + ph - l : i + ph;
            if (i < l && ph < l && h[i] != r[j[3:0]])
               ok = 1'b0;
         end
         rot_match = rot_match | ok;
      end
   endfunction : rot_match

   assign ref_bits = (len == 5'd16) ? {cfg.hi, cfg.lo}
                   : ({8'h00, cfg.hi} >> (5'd8 - len));
   assign match    = rot_match(hist, ref_bits, len);
   assign win_end  = (cyc_cnt == CW'(INTEG_CYCLES - 1));
   // errors and framing bits spoil a few windows; half is the margin
   assign pass     = (bit_cnt != '0) && ({bad_cnt, 1'b0} < {1'b0, bit_cnt});

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         hist <= 16'h0000;
      else if (bit_en)
         hist <= {hist[14:0], bit_in};
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || restart || !enable || win_end)
      begin
         cyc_cnt <= '0;
         bit_cnt <= '0;
         bad_cnt <= '0;
      end
      else
      begin
         cyc_cnt <= cyc_cnt + CW'(1);
         bit_cnt <= bit_cnt + CW'(bit_en);
         bad_cnt <= bad_cnt + CW'(bit_en && !match);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || !enable)
         detected <= 1'b0;
      else if (win_end)
         detected <= pass;
   end

   property p_restart;
      @(posedge clk) disable iff (sys_rst)
      restart |=> (cyc_cnt == '0) && (bit_cnt == '0) && (bad_cnt == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("restart ignored");

   property p_hold;
      @(posedge clk) disable iff (sys_rst)
      !$stable(detected) |-> $past(win_end) || !$past(enable) || $past(sys_rst);
   endproperty
   a_hold: assert property (p_hold) else $error("detect changed mid window");

   property p_off;
      @(posedge clk) disable iff (sys_rst)
      !enable [*2] |-> !detected;
   endproperty
   a_off: assert property (p_off) else $error("detect outside T1");
endmodule : lcg_detector

//--- verification/lcg_line_partner.sv
module lcg_line_partner
   import lcg_pkg::*;
#(
   parameter int ERR_EVERY  = 100,
   parameter int FRAME_BITS = 193
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // code sent toward the framer
   input  wire logic        send_en,
   input  wire logic [15:0] code,
   input  wire logic [4:0]  code_len,
   // bits leaving the framer
   input  wire logic        tx_bit_valid,
   input  wire logic        tx_data_out,
   // bits arriving at the framer
   output lcg_line_t        rx_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       tx_q[$];
   logic       ph = 1'b0;
   logic [4:0] pos;
   int         cnt;
   logic       b;
   always @(posedge clk)
   begin
      if (tx_bit_valid)
         tx_q.push_back(tx_data_out);
      ph <= ~ph;
      if (sys_rst)
      begin
         pos <= 5'd3;
         cnt <= 0;
         rx_line <= '0;
      end
      else if (send_en && ph)
      begin
         b = code[5'd15 - pos];
         cnt <= cnt + 1;
         // extra framing bit, code position held
         if (cnt % FRAME_BITS == FRAME_BITS - 1)
            b = ~rx_line.data;
         else
         begin
            pos <= (pos >= code_len - 5'd1) ? 5'd0 : pos + 5'd1;
            if (cnt % ERR_EVERY == ERR_EVERY / 2)
               b = ~b;
         end
         rx_line <= {1'b1, 1'b0, b};
      end
      else
         // idle line wanders, never holds the last bit
         rx_line <= {1'b0, 1'b0, ~rx_line.data};
   end
endmodule : lcg_line_partner

//--- verification/tb_t1_inband_loop_code_gen_detect.sv
`include "lcg_defines.svh"
module tb_t1_inband_loop_code_gen_detect
   import lcg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [19:0] TXT [9] = '{20'h0_ffff, 20'h1_aaaa, 20'h2_c05a, 20'h3_9999,
      20'h4_8033, 20'h5_b033, 20'h6_e433, 20'h7_3c3c, 20'h8_a50f};
   localparam logic [10:0] REGS [16] = '{`LCG_IX_RX_LEN, `LCG_IX_LATCH, `LCG_IX_SP_HI,
      `LCG_IX_SP_LO, `LCG_IX_MASK, `LCG_IX_UP_HI, `LCG_IX_UP_LO, `LCG_IX_DN_HI,
      `LCG_IX_DN_LO, `LCG_IX_LIVE, `LCG_IX_TX_CTL3, `LCG_IX_TX_CTL4, `LCG_IX_TX_CODE1,
      `LCG_IX_TX_CODE2, `LCG_IX_SP_LEN, `LCG_IX_MODE};
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [13:0] s_axi_awaddr = '0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0]  s_axi_wstrb = '0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [13:0] s_axi_araddr = '0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   lcg_line_t   tx_line_in = '0;
   lcg_line_t   rx_line_in;
   logic        tx_data_out;
   logic        tx_bit_valid;
   logic        tx_loop_active;
   logic        loop_code_irq;
   logic        p_on = 1'b0;
   logic [15:0] p_code = '0;
   logic [4:0]  p_len = 5'd1;
   int          bad_count = 0;
   int          checks = 0;
   int          cyc = 0;
   always #4 clk = ~clk;
   lcg_top #(.FRAMER_NUM(1), .INTEG_CYCLES(200)) dut_u (.clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_line_in(tx_line_in),
      .tx_data_out(tx_data_out), .tx_bit_valid(tx_bit_valid),
      .tx_loop_active(tx_loop_active), .rx_line_in(rx_line_in),
      .loop_code_irq(loop_code_irq));
   lcg_line_partner pm_u (.clk(clk), .sys_rst(sys_rst), .send_en(p_on), .code(p_code),
      .code_len(p_len), .tx_bit_valid(tx_bit_valid), .tx_data_out(tx_data_out),
      .rx_line(rx_line_in));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [10:0] ix, input logic [7:0] d, input logic [1:0] er);
      logic a_ok;
      logic w_ok;
      a_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= {1'b0, ix, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(a_ok && w_ok))
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            a_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0000_0000, s_axi_bresp}, {30'h0000_0000, er});
   endtask : wr
   task automatic rd(input logic [10:0] ix, input logic [7:0] exp, input logic [1:0] er,
                     input string nm);
      @(posedge clk);
      s_axi_araddr <= {1'b0, ix, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(nm, s_axi_rdata, {24'h00_0000, exp});
      chk("rresp", {30'h0000_0000, s_axi_rresp}, {30'h0000_0000, er});
   endtask : rd
   // passthrough data is bit index / 2, so a wrong source shows at once
   task automatic tx_run(input int n, input int fs_at, input int l, input logic [15:0] pat,
                         input logic act);
      logic e;
      int   k;
      pm_u.tx_q.delete();
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         tx_line_in <= {1'b1, 1'(i == fs_at), 1'(i >> 1)};
      end
      @(posedge clk);
      tx_line_in <= '0;
      repeat (2) @(posedge clk);
      chk("tx_count", 32'(pm_u.tx_q.size()), 32'(n));
      for (int i = 0; i < n; i++)
      begin
         k = ((l & (l - 1)) == 0) ? i % 16 : i % l;
         e = (!act || i == fs_at) ? 1'(i >> 1) : pat[15 - k];
         chk("tx_bit", 32'(pm_u.tx_q[i]), 32'(e));
      end
   endtask : tx_run
   task automatic det(input logic [15:0] c, input logic [4:0] l, input logic [7:0] lv,
                      input logic [7:0] la);
      @(posedge clk);
      p_code <= c;
      p_len <= l;
      p_on <= 1'b1;
      repeat (800) @(posedge clk);
      rd(`LCG_IX_LIVE, lv, 2'b00, "live");
      rd(`LCG_IX_LATCH, la, 2'b00, "latched");
   endtask : det
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (REGS[i])
         rd(REGS[i], (REGS[i] == `LCG_IX_MODE) ? 8'h01 : 8'h00, 2'b00, "reset_val");
      rd(11'h000, 8'h00, 2'b10, "unmapped");
      rd(11'h282, 8'h00, 2'b10, "framer_two");
      wr(11'h282, 8'h55, 2'b10);
      wr(`LCG_IX_LIVE, 8'hff, 2'b00);
      rd(`LCG_IX_LIVE, 8'h00, 2'b00, "live_ro");
      // no framing slot while sweeping every length
      wr(`LCG_IX_MODE, 8'h03, 2'b00);
      foreach (TXT[j])
      begin
         wr(`LCG_IX_TX_CTL3, 8'h00, 2'b00);
         wr(`LCG_IX_TX_CODE1, TXT[j][15:8], 2'b00);
         wr(`LCG_IX_TX_CODE2, TXT[j][7:0], 2'b00);
         wr(`LCG_IX_TX_CTL4, {4'h0, TXT[j][19:16]}, 2'b00);
         wr(`LCG_IX_TX_CTL3, 8'h01, 2'b00);
         // flag launched at the response edge, look one edge later
         @(posedge clk);
         chk("loop_active", 32'(tx_loop_active), 32'd1);
         tx_run(24, -1, TXT[j][19] ? 16 : int'(TXT[j][18:16]) + 1, TXT[j][15:0], 1'b1);
      end
      wr(`LCG_IX_TX_CTL3, 8'h00, 2'b00);
      @(posedge clk);
      chk("loop_idle", 32'(tx_loop_active), 32'd0);
      tx_run(10, -1, 16, 16'h0000, 1'b0);
      wr(`LCG_IX_MODE, 8'h01, 2'b00);
      wr(`LCG_IX_TX_CTL3, 8'h01, 2'b00);
      tx_run(30, 0, 16, 16'ha50f, 1'b1);
      wr(`LCG_IX_MODE, 8'h00, 2'b00);
      repeat (2) @(posedge clk);
      chk("loop_e1", 32'(tx_loop_active), 32'd0);
      tx_run(10, -1, 16, 16'ha50f, 1'b0);
      wr(`LCG_IX_MODE, 8'h01, 2'b00);
      wr(`LCG_IX_TX_CTL3, 8'h00, 2'b00);
      wr(`LCG_IX_RX_LEN, 8'h74, 2'b00);
      wr(`LCG_IX_UP_HI, 8'h80, 2'b00);
      wr(`LCG_IX_UP_LO, 8'h13, 2'b00);
      wr(`LCG_IX_DN_HI, 8'h3c, 2'b00);
      wr(`LCG_IX_DN_LO, 8'h3c, 2'b00);
      wr(`LCG_IX_SP_LEN, 8'h08, 2'b00);
      wr(`LCG_IX_SP_HI, 8'ha5, 2'b00);
      wr(`LCG_IX_SP_LO, 8'h0f, 2'b00);
      rd(`LCG_IX_RX_LEN, 8'h74, 2'b00, "rx_len");
      det(16'h8000, 5'd5, 8'h01, 8'h01);
      chk("irq_masked", 32'(loop_code_irq), 32'd0);
      wr(`LCG_IX_MASK, 8'h01, 2'b00);
      repeat (2) @(posedge clk);
      chk("irq_on", 32'(loop_code_irq), 32'd1);
      wr(`LCG_IX_LATCH, 8'h01, 2'b00);
      rd(`LCG_IX_LATCH, 8'h00, 2'b00, "w1c");
      chk("irq_off", 32'(loop_code_irq), 32'd0);
      wr(`LCG_IX_UP_LO, 8'h13, 2'b00);
      rd(`LCG_IX_LIVE, 8'h01, 2'b00, "live_kept");
      det(16'h3c00, 5'd8, 8'h02, 8'h12);
      chk("irq_mask1", 32'(loop_code_irq), 32'd0);
      wr(`LCG_IX_LATCH, 8'hff, 2'b00);
      wr(`LCG_IX_MASK, 8'h04, 2'b00);
      det(16'ha50f, 5'd16, 8'h04, 8'h24);
      chk("irq_spare", 32'(loop_code_irq), 32'd1);
      wr(`LCG_IX_LATCH, 8'hff, 2'b00);
      p_on <= 1'b0;
      // host waits 800 cycles for the code to go
      repeat (800) @(posedge clk);
      rd(`LCG_IX_LIVE, 8'h00, 2'b00, "live_gone");
      rd(`LCG_IX_LATCH, 8'h40, 2'b00, "latch_clr");
      report_and_stop();
   end
endmodule : tb_t1_inband_loop_code_gen_detect
